// ### rtl/scp_pkg.sv
// Shared constants and helpers for the switch control pin logic.
// Assumes a single 10 MHz core clock and pins that are synchronised before use.
`default_nettype none
package scp_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int         SCP_NCH        = 6;
  localparam int         SCP_FRAME_BITS = 16;
  localparam int         SCP_CNT_W      = 5;
  localparam logic [4:0] SCP_FRAME_LEN  = 5'h10;
  localparam logic [4:0] SCP_CNT_MAX    = 5'h1F;

  // ****************************************************************
  // Synchronised pin vector layout
  // ****************************************************************
  localparam int SCP_PIN_W   = 11;
  localparam int SCP_P_SI    = 0;
  localparam int SCP_P_CSN   = 1;
  localparam int SCP_P_SCLK  = 2;
  localparam int SCP_P_EDGE  = 3;
  localparam int SCP_P_IN    = 4;
  localparam int SCP_P_GEN   = 10;

  // ****************************************************************
  // Channel control codes, two bits per channel in the frame
  // ****************************************************************
  localparam logic [1:0] SCP_MODE_PAR  = 2'h0;
  localparam logic [1:0] SCP_MODE_ON   = 2'h1;
  localparam logic [1:0] SCP_MODE_OFF  = 2'h2;
  localparam logic [1:0] SCP_MODE_PAR2 = 2'h3;

  // ****************************************************************
  // Reset values and status word padding
  // ****************************************************************
  localparam logic [11:0] SCP_CTRL_RST  = 12'h000;
  localparam logic [5:0]  SCP_DIAG_RST  = 6'h00;
  // Chip select flop resets to its idle level so release cannot start a frame
  localparam logic [10:0] SCP_SYNC_RST  = 11'h002;
  localparam logic [15:0] SCP_WORD_RST  = 16'h0000;
  localparam logic [2:0]  SCP_TX_PAD    = 3'h0;

  typedef enum logic {SCP_IDLE, SCP_SHIFT} scp_shift_st_t;

  // Decodes one channel's request from its mode pair and parallel input
  function automatic logic scp_chan_on(input logic [1:0] mode, input logic par_in);
    case (mode)
      SCP_MODE_ON:  scp_chan_on = 1'b1;
      SCP_MODE_OFF: scp_chan_on = 1'b0;
      default:      scp_chan_on = par_in;
    endcase
  endfunction : scp_chan_on

endpackage : scp_pkg
`default_nettype wire

// ### rtl/scp_spi_if.sv
// Frame exchange between the serial shifter and the control core.
// Assumes both ends run on mclk.
`timescale 1ns/1ps
`default_nettype none
interface scp_spi_if;
  logic        frame_ok;
  logic        frame_start;
  logic [15:0] rx_word;
  logic [15:0] tx_word;
  modport shift (output frame_ok, output frame_start, output rx_word, input tx_word);
  modport core  (input frame_ok, input frame_start, input rx_word, output tx_word);
endinterface : scp_spi_if
`default_nettype wire

// ### rtl/scp_spi_shift.sv
// Serial frame shifter: oversamples the synchronised serial pins on mclk.
// Assumes all serial inputs already passed two flip-flops.
`timescale 1ns/1ps
`default_nettype none
module scp_spi_shift
  import scp_pkg::*;
(
  input  wire logic  mclk,
  input  wire logic  arst_n,
  input  wire logic  sclk_s,
  input  wire logic  cs_n_s,
  input  wire logic  si_s,
  input  wire logic  edge_sel_s,
  output logic       so_o,
  output logic       so_oe,
  scp_spi_if.shift   bus
);

  scp_shift_st_t  st_r,    st_nxt;
  logic           sclk_d_r;
  logic [4:0]     cnt_r,   cnt_nxt;
  logic [15:0]    rx_r,    rx_nxt;
  logic [15:0]    tx_r,    tx_nxt;
  logic           so_r,    so_nxt;
  logic           ok_r,    ok_nxt;
  logic           rise,    fall, sample, change;

  // ****************************************************************
  // Edge selection
  // ****************************************************************
  assign rise   = sclk_s & ~sclk_d_r;
  assign fall   = ~sclk_s & sclk_d_r;
  assign sample = edge_sel_s ? fall : rise;
  assign change = edge_sel_s ? rise : fall;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    so_nxt = so_r;
    ok_nxt = 1'b0;
    case (st_r)
      SCP_IDLE: begin
        if (!cs_n_s) begin
          st_nxt = SCP_SHIFT;
          cnt_nxt = '0;
          tx_nxt = bus.tx_word;
          so_nxt = bus.tx_word[SCP_FRAME_BITS-1];
        end
      end
      SCP_SHIFT: begin
        if (cs_n_s) begin
          st_nxt = SCP_IDLE;
          ok_nxt = (cnt_r == SCP_FRAME_LEN);
        end else begin
          if (sample && cnt_r != SCP_CNT_MAX) begin
            rx_nxt = {rx_r[SCP_FRAME_BITS-2:0], si_s};
            cnt_nxt = cnt_r + 5'h01;
          end
          // The idle level produces a leading change edge; it must not shift
          if (change && cnt_r != '0) begin
            tx_nxt = {tx_r[SCP_FRAME_BITS-2:0], 1'b0};
            so_nxt = tx_r[SCP_FRAME_BITS-2];
          end
        end
      end
      default: st_nxt = SCP_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= SCP_IDLE;
      sclk_d_r <= 1'b0;
      cnt_r <= '0;
      rx_r <= SCP_WORD_RST;
      tx_r <= SCP_WORD_RST;
      so_r <= 1'b0;
      ok_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      sclk_d_r <= sclk_s;
      cnt_r <= cnt_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      so_r <= so_nxt;
      ok_r <= ok_nxt;
    end
  end

  assign so_o            = so_r;
  assign so_oe           = (st_r == SCP_SHIFT);
  assign bus.frame_ok    = ok_r;
  assign bus.rx_word     = rx_r;
  assign bus.frame_start = (st_r == SCP_IDLE) && !cs_n_s;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  chk_frame_len: assert property (ok_r |-> $past(cnt_r) == SCP_FRAME_LEN)
    else $error("frame accepted with wrong edge count");
  chk_rise_sample: assert property (st_r == SCP_SHIFT && !cs_n_s && !edge_sel_s && rise && cnt_r < SCP_FRAME_LEN
    |=> rx_r[0] == $past(si_s) && cnt_r == $past(cnt_r) + 5'h01)
    else $error("rising edge not sampled");
  chk_fall_sample: assert property (st_r == SCP_SHIFT && !cs_n_s && edge_sel_s && fall && cnt_r < SCP_FRAME_LEN
    |=> rx_r[0] == $past(si_s))
    else $error("falling edge not sampled");
  chk_cs_ignore: assert property (cs_n_s && st_r == SCP_IDLE |=> $stable(rx_r) && !ok_r)
    else $error("serial clock acted on while deselected");

  cov_frame_ok:  cover property (ok_r);
  cov_edge_high: cover property (edge_sel_s && ok_r);

endmodule : scp_spi_shift
`default_nettype wire

// ### rtl/scp_switch_ctrl.sv
// Control and indication pin logic of a six-channel power switch.
// Assumes all pins are asynchronous to mclk and the error sources are on mclk.
`timescale 1ns/1ps
`default_nettype none

module scp_switch_ctrl
  import scp_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        global_output_enable,
  input  wire logic [5:0]  channel_control_input,
  input  wire logic        spi_edge_select,
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_si,
  input  wire logic [5:0]  chan_err_in,
  input  wire logic        overheat_in,
  output logic             spi_so,
  output logic             spi_so_oe,
  output logic [5:0]       power_on,
  output logic [4:0]       channel_diag_output,
  output logic             channel_six_diag_or_overheat,
  output logic             fault_n_out,
  output logic             fault_n_oe,
  output logic             standby,
  output logic             sclk_pullup_en,
  output logic             sclk_pulldown_en,
  output logic [5:0]       chan_pulldown_en
);

  logic [10:0] sync1_r, sync2_r, sync_nxt;
  logic [1:0]  rel_r,   rel_nxt;
  logic [11:0] ctrl_r,  ctrl_nxt;
  logic [5:0]  diag_r,  diag_nxt;
  logic        ot_r,    ot_nxt;
  logic [5:0]  power_r, power_nxt;
  logic [5:0]  dpin_r,  dpin_nxt;
  logic        pull_r,  pull_nxt;
  logic [5:0]  in_s;
  logic [11:0] tx_pairs;

  scp_spi_if bus ();

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  assign sync_nxt = {global_output_enable, channel_control_input, spi_edge_select,
                     spi_sclk, spi_cs_n, spi_si};
  assign rel_nxt  = {rel_r[0], 1'b1};
  assign in_s     = sync2_r[SCP_P_IN +: SCP_NCH];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= SCP_SYNC_RST;
      sync2_r <= SCP_SYNC_RST;
      rel_r <= 2'h0;
    end else begin
      sync1_r <= sync_nxt;
      sync2_r <= sync1_r;
      rel_r <= rel_nxt;
    end
  end

  // ****************************************************************
  // Serial frame shifter
  // ****************************************************************
  scp_spi_shift u_shift (
    .mclk       (mclk),
    .arst_n     (arst_n),
    .sclk_s     (sync2_r[SCP_P_SCLK]),
    .cs_n_s     (sync2_r[SCP_P_CSN]),
    .si_s       (sync2_r[SCP_P_SI]),
    .edge_sel_s (sync2_r[SCP_P_EDGE]),
    .so_o       (spi_so),
    .so_oe      (spi_so_oe),
    .bus        (bus.shift)
  );

  // ****************************************************************
  // Channel control and diagnosis
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < SCP_NCH; gi++) begin : g_ch
      // Held off until the synchronised reset release; enable low overrides all
      assign power_nxt[gi] = rel_r[1] & sync2_r[SCP_P_GEN]
                             & scp_chan_on(ctrl_r[2*gi +: 2], in_s[gi]);
      assign tx_pairs[2*gi +: 2] = {diag_r[gi], power_r[gi]};
    end
  endgenerate

  assign bus.tx_word = {SCP_TX_PAD, ot_r, tx_pairs};

  always_comb begin
    ctrl_nxt = bus.frame_ok ? bus.rx_word[11:0] : ctrl_r;
    // A new error in the clearing cycle still latches
    diag_nxt = (bus.frame_ok ? SCP_DIAG_RST : diag_r) | chan_err_in;
    ot_nxt   = (bus.frame_ok ? 1'b0 : ot_r) | overheat_in;
    dpin_nxt = in_s;
    dpin_nxt[SCP_NCH-1] = in_s[SCP_NCH-1] & ~ot_r;
    pull_nxt = ~sync2_r[SCP_P_EDGE];
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= SCP_CTRL_RST;
      diag_r <= SCP_DIAG_RST;
      ot_r <= 1'b0;
      power_r <= '0;
      dpin_r <= '0;
      pull_r <= 1'b1;
    end else begin
      ctrl_r <= ctrl_nxt;
      diag_r <= diag_nxt;
      ot_r <= ot_nxt;
      power_r <= power_nxt;
      dpin_r <= dpin_nxt;
      pull_r <= pull_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign power_on                     = power_r;
  assign channel_diag_output          = dpin_r[SCP_NCH-2:0];
  assign channel_six_diag_or_overheat = dpin_r[SCP_NCH-1];
  assign fault_n_out                  = 1'b0;
  assign fault_n_oe                   = (|diag_r) | ot_r;
  assign standby                      = ~rel_r[1];
  assign sclk_pullup_en               = pull_r;
  assign sclk_pulldown_en             = ~pull_r;
  // Pad pull-downs stay on so a floating input reads as off
  assign chan_pulldown_en             = {SCP_NCH{1'b1}};

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  chk_enable_forces_off: assert property (!sync2_r[SCP_P_GEN] |=> power_on == '0)
    else $error("outputs on while enable low");
  chk_standby_holds_off: assert property (standby |-> power_on == '0 && chan_pulldown_en != '0)
    else $error("output on during standby");
  chk_fault_on_error: assert property ((|chan_err_in) || overheat_in |=> fault_n_oe && !fault_n_out)
    else $error("fault pin not pulled on error");
  chk_fault_release: assert property (bus.frame_ok && !(|chan_err_in) && !overheat_in |=> !fault_n_oe)
    else $error("fault pin not released after clear");
  chk_pull_follows: assert property (1'b1 |=> sclk_pullup_en == !$past(sync2_r[SCP_P_EDGE])
    && sclk_pulldown_en != sclk_pullup_en)
    else $error("serial clock pull wrong");
  chk_diag_follows: assert property (1'b1 |=> channel_diag_output == $past(in_s[SCP_NCH-2:0]))
    else $error("diagnostic pin does not follow input");
  chk_overheat_diag: assert property (ot_r |=> !channel_six_diag_or_overheat)
    else $error("overheat not shown on sixth pin");
  chk_sync_delay: assert property (rel_r[1] && $past(rel_r[1]) && sync2_r[SCP_P_GEN] && ctrl_r[1:0] == SCP_MODE_PAR
    && $stable(ctrl_r) |=> power_on[0] == $past(sync2_r[SCP_P_IN]))
    else $error("parallel input not taken through synchroniser");

  // ****************************************************************
  // Latch, mode and synchroniser checks
  // ****************************************************************
  // A new error in the clearing cycle must keep the pin pulled
  chk_fault_set_wins: assert property (bus.frame_ok && (|chan_err_in)
    |=> fault_n_oe)
    else $error("error lost in clearing cycle");

  chk_diag_hold: assert property (diag_r[2] && !bus.frame_ok
    |=> diag_r[2])
    else $error("latched error dropped without clear");

  chk_ot_hold: assert property (ot_r && !bus.frame_ok
    |=> ot_r)
    else $error("overheat latch dropped without clear");

  chk_diag_clear: assert property (bus.frame_ok && !chan_err_in[2]
    |=> !diag_r[2])
    else $error("error latch not cleared");

  chk_ot_clear: assert property (bus.frame_ok && !overheat_in
    |=> !ot_r)
    else $error("overheat latch not cleared");

  chk_ctrl_on_frame: assert property (bus.frame_ok
    |=> ctrl_r == $past(bus.rx_word[11:0]))
    else $error("accepted frame not written");

  chk_ctrl_hold: assert property (!bus.frame_ok
    |=> $stable(ctrl_r))
    else $error("modes changed without a frame");

  chk_forced_on: assert property (rel_r[1] && sync2_r[SCP_P_GEN] && ctrl_r[1:0] == SCP_MODE_ON
    |=> power_on[0])
    else $error("forced-on channel is off");

  chk_forced_off: assert property (ctrl_r[3:2] == SCP_MODE_OFF
    |=> !power_on[1])
    else $error("forced-off channel is on");

  chk_sixth_follows: assert property (!ot_r
    |=> channel_six_diag_or_overheat == $past(in_s[SCP_NCH-1]))
    else $error("sixth diagnostic pin does not follow input");

  // The second stage may only ever copy the first
  chk_sync_two_stage: assert property (1'b1
    |=> sync2_r == $past(sync1_r))
    else $error("pin synchroniser skipped a stage");

  cov_fault:    cover property ($rose(fault_n_oe));
  cov_power:    cover property (power_on != '0);
  cov_disable:  cover property ($fell(sync2_r[SCP_P_GEN]) && power_on != '0);

endmodule : scp_switch_ctrl
`default_nettype wire

// ### verification/scp_host_model.sv
// Host side of the serial link: frames words onto the serial pins of the switch.
// Assumes the bench calls xfer from one process and that mclk runs at 10 MHz.
`timescale 1ns/1ps
`default_nettype none
module scp_host_model
  import scp_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        spi_so,
  input  wire logic        spi_so_oe,
  output logic             spi_sclk,
  output logic             spi_cs_n,
  output logic             spi_si
);
  initial begin
    spi_sclk = 1'b1;
    spi_cs_n = 1'b1;
    spi_si   = 1'b0;
  end

  // Half period of four mclk gives the 800 ns serial clock
  task automatic xfer(input logic sel, input logic [15:0] tx, input int nbits, input logic use_cs,
                      output logic [15:0] rx);
    rx = 16'h0000;
    spi_sclk = !sel;
    repeat (4) @(negedge mclk);
    spi_cs_n = !use_cs;
    repeat (4) @(negedge mclk);
    for (int i = 0; i < nbits; i++) begin
      spi_sclk = sel;
      spi_si   = (i < 16) ? tx[15 - i] : 1'b0;
      repeat (4) @(negedge mclk);
      spi_sclk = !sel;
      rx = {rx[14:0], spi_oe_val()};
      repeat (4) @(negedge mclk);
    end
    spi_cs_n = 1'b1;
    spi_si   = 1'b0;                       // Data line driven low while deselected
    repeat (8) @(negedge mclk);
  endtask : xfer

  // A released line has no pull, so it shows the inverse of its last level
  function automatic logic spi_oe_val();
    spi_oe_val = spi_so_oe ? spi_so : ~spi_so;
  endfunction : spi_oe_val
endmodule : scp_host_model
`default_nettype wire

// ### verification/scp_switch_ctrl_tb.sv
// Self-checking bench for the switch control pin logic.
// Assumes the host model drives the serial pins; the bench drives all other inputs.
`timescale 1ns/1ps
`default_nettype none
module scp_switch_ctrl_tb;
  import scp_pkg::*;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic        gen = 1'b1;
  logic [5:0]  cin = 6'h00;
  logic        esel = 1'b0;
  logic [5:0]  err = 6'h00;
  logic        oh = 1'b0;
  wire         sclk, csn, si, so, so_oe, diag6, fault_n, fault_oe, stby, pu, pd;
  wire  [5:0]  pon, cpd;
  wire  [4:0]  diag;
  wire         fault_pin = fault_oe ? fault_n : 1'b1;
  logic [15:0] rx;
  int          errors = 0;
  int          checks_done = 0;

  always #50 mclk = ~mclk;

  scp_switch_ctrl dut_u (.mclk(mclk), .arst_n(arst_n), .global_output_enable(gen),
    .channel_control_input(cin), .spi_edge_select(esel), .spi_sclk(sclk), .spi_cs_n(csn),
    .spi_si(si), .chan_err_in(err), .overheat_in(oh), .spi_so(so), .spi_so_oe(so_oe),
    .power_on(pon), .channel_diag_output(diag), .channel_six_diag_or_overheat(diag6),
    .fault_n_out(fault_n), .fault_n_oe(fault_oe), .standby(stby), .sclk_pullup_en(pu),
    .sclk_pulldown_en(pd), .chan_pulldown_en(cpd));
  scp_host_model host_u (.mclk(mclk), .spi_so(so), .spi_so_oe(so_oe), .spi_sclk(sclk),
    .spi_cs_n(csn), .spi_si(si));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  task automatic wrap_up();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    chk(pon, 16'h0000, "outputs in reset");
    chk(stby, 16'h0001, "standby in reset");
    chk(fault_pin, 16'h0001, "fault in reset");
    chk({pu, pd}, 16'h0002, "sclk pull");
    arst_n = 1'b1;
    cyc(4);
    chk(stby, 16'h0000, "standby after release");
    chk(cpd, 16'h003F, "input pull-downs");
  endtask : t_reset

  task automatic t_parallel();
    for (int i = 0; i < 6; i++) begin
      cin = 6'h01 << i;
      cyc(2);
      chk(pon, 16'h0000, "not yet synced");
      cyc(1);
      chk(pon, 16'h0001 << i, "parallel on");
      chk({diag6, diag}, cin, "diag follows");
      cin = 6'h00;
      cyc(4);
    end
  endtask : t_parallel

  task automatic t_enable();
    cin = 6'h3F;
    cyc(4);
    chk(pon, 16'h003F, "all on");
    gen = 1'b0;
    cyc(4);
    chk(pon, 16'h0000, "enable low");
    chk(diag, 16'h001F, "diag with enable low");
    gen = 1'b1;
    cin = 6'h00;
    cyc(4);
  endtask : t_enable

  task automatic t_spi(input logic sel);
    esel = sel;
    cyc(4);
    chk({pu, pd}, {14'h0, !sel, sel}, "sclk pull by select");
    cin = 6'h0C;
    // Modes ch0 on, ch1 off, ch2 parallel, ch3 parallel, ch4 on, ch5 off
    host_u.xfer(sel, 16'h09C9, 16, 1'b1, rx);
    chk(pon, 16'h001D, "frame modes");
    host_u.xfer(sel, 16'h0000, 16, 1'b1, rx);
    chk(rx, 16'h0151, "status readback");
    chk(pon, 16'h000C, "back to parallel");
    cin = 6'h00;
  endtask : t_spi

  task automatic t_refuse();
    esel = 1'b0;
    host_u.xfer(1'b0, 16'h0555, 15, 1'b1, rx);
    chk(pon, 16'h0000, "short frame dropped");
    host_u.xfer(1'b0, 16'h0555, 16, 1'b0, rx);
    chk(pon, 16'h0000, "clock while deselected");
    chk(so_oe, 16'h0000, "serial out released");
    host_u.xfer(1'b0, 16'h0555, 16, 1'b1, rx);
    chk(pon, 16'h003F, "all forced on");
    arst_n = 1'b0;
    cyc(2);
    chk({stby, pon}, 16'h0040, "mid-run reset");
    arst_n = 1'b1;
    cyc(4);
    chk(pon, 16'h0000, "modes cleared");
  endtask : t_refuse

  task automatic t_fault();
    cin = 6'h20;
    cyc(4);
    err = 6'h04;
    cyc(1);
    err = 6'h00;
    chk(fault_pin, 16'h0000, "fault pulls low");
    oh = 1'b1;
    cyc(1);
    oh = 1'b0;
    cyc(2);
    chk(diag6, 16'h0000, "overheat on ch6 pin");
    host_u.xfer(1'b0, 16'h0000, 16, 1'b1, rx);
    chk(rx, 16'h1420, "latched status");
    chk(fault_pin, 16'h0001, "fault released");
    chk(diag6, 16'h0001, "ch6 pin back");
    cin = 6'h00;
  endtask : t_fault

  // ****************************************************************
  // Sequence and watchdog
  // ****************************************************************
  initial begin
    cyc(12);
    t_reset();
    t_parallel();
    t_enable();
    t_spi(1'b0);
    t_spi(1'b1);
    t_refuse();
    t_fault();
    wrap_up();
  end

  // Whole run is near 1240 cycles; allow about sixteen times that
  initial begin
    #2000000;
    errors++;
    wrap_up();
  end
endmodule : scp_switch_ctrl_tb
`default_nettype wire
